// file: test/bhc_ctrl_checker.sv
// Assertions on the bus hold, inquire and interrupt control ports.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
module bhc_ctrl_checker (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic hold_req_in,
  input wire logic lock_seq_in,
  input wire logic cyc_start_in,
  input wire logic cyc_allow_out,
  input wire logic bus_grant_ack_out,
  input wire logic bus_float_out,
  input wire logic snoop_addr_strobe_n_in,
  input wire logic snoop_found_in,
  input wire logic snoop_modified_in,
  input wire logic snoop_invalidate_in,
  input wire logic snoop_modified_hit_n_out,
  input wire logic snoop_update_out,
  input wire logic snoop_make_invalid_out,
  input wire logic instr_boundary_in,
  input wire logic numeric_error_ctrl_bit_in,
  input wire logic fp_target_sensitive_in,
  input wire logic fp_vector_out,
  input wire logic fp_stall_out,
  input wire logic irq_flag_in,
  input wire logic irq_take_out,
  input wire logic fill_burst_out
);
  default clocking dc @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_grant_idle: assert property (
    hold_req_in && cyc_allow_out && !lock_seq_in && !cyc_start_in |=> bus_grant_ack_out)
    else $error("grant missing on idle bus");
  a_grant_drop: assert property (
    bus_grant_ack_out && !hold_req_in |=> !bus_grant_ack_out) else $error("grant not dropped");
  a_float_grant: assert property (
    bus_grant_ack_out |-> bus_float_out) else $error("bus not floated");
  a_lock_hold: assert property (
    lock_seq_in && !bus_grant_ack_out |=> !bus_grant_ack_out) else $error("grant inside lock");
  a_snoop_modified_hit_n_answer: assert property (
    !snoop_addr_strobe_n_in && $past(snoop_addr_strobe_n_in) && snoop_modified_hit_n_out
    && snoop_found_in && snoop_modified_in |=> !snoop_modified_hit_n_out)
    else $error("modified hit missing");
  a_snoop_state: assert property (
    !snoop_addr_strobe_n_in && $past(snoop_addr_strobe_n_in) && snoop_modified_hit_n_out
    && snoop_found_in |=> snoop_update_out && snoop_make_invalid_out == $past(snoop_invalidate_in))
    else $error("line state update wrong");
  a_fp_vector: assert property (
    fp_vector_out |-> $past(instr_boundary_in) && $past(numeric_error_ctrl_bit_in)
    && $past(fp_target_sensitive_in)) else $error("vector without cause");
  a_stall_cause: assert property (
    $rose(fp_stall_out) |-> !$past(numeric_error_ctrl_bit_in) && $past(fp_target_sensitive_in))
    else $error("stall without cause");
  a_irq_take: assert property (
    irq_take_out |-> $past(irq_flag_in) && $past(instr_boundary_in)) else $error("irq taken wrongly");
  c_grant: cover property (bus_grant_ack_out && bus_float_out);
  c_snoop_modified_hit_n: cover property (!snoop_modified_hit_n_out);
  c_burst: cover property (fill_burst_out);
endmodule

bind bhc_ctrl bhc_ctrl_checker u_checker (.*);

// file: test/bhc_sys_model.sv
// Behavioural system logic answering bus cycles with burst readies.
// Assumes the bench loads one cycle at a time through go_in.
`timescale 1ns/1ns
module bhc_sys_model (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic go_in,
  input wire logic ken_in,
  input wire logic [2:0] beats_in,
  input wire logic [1:0] gap_in,
  output logic burst_ready_n_out,
  output logic cacheable_n_out
);
  int left;
  int wait_n;
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      left <= 0;
      wait_n <= 0;
    end else if (go_in) begin
      left <= beats_in;
      wait_n <= gap_in;
    end else if (wait_n > 0) begin
      wait_n <= wait_n - 1;
    end else if (left > 0) begin
      left <= left - 1;
    end
  end
  assign burst_ready_n_out = !(left > 0 && wait_n == 0);
  // Valid for the whole cycle, next-address included; outside a cycle the inverse shows.
  assign cacheable_n_out = (left > 0) ? ~ken_in : ken_in;
endmodule

// file: test/cpu_bus_hold_snoop_maskable_irq_in_ctrl_tb_top.sv
// Self-checking bench for the bus hold, inquire and interrupt control block.
// Assumes the design, its checker bind and the system logic model compile first.
`timescale 1ns/1ns
module cpu_bus_hold_snoop_maskable_irq_in_ctrl_tb_top;
  logic sys_clk_in = 1'b0, rst_n_in = 1'b0, hold_req_in = 1'b0, backoff_n_in = 1'b1;
  logic next_addr_n_in = 1'b1, snoop_addr_strobe_n_in = 1'b1, snoop_invalidate_in = 1'b0;
  logic ignore_fp_error_n_in = 1'b1, maskable_irq_in = 1'b0, init_in = 1'b0, nmi_in = 1'b0;
  logic sys_mgmt_irq_n_in = 1'b1, cyc_start_in = 1'b0, cyc_read_in = 1'b0, cyc_cache_in = 1'b0;
  logic cyc_writeback_in = 1'b0, page_cache_disable_in = 1'b0, lock_seq_in = 1'b0, go = 1'b0;
  logic snoop_found_in = 1'b0, snoop_modified_in = 1'b0, instr_boundary_in = 1'b0, ken = 1'b0;
  logic irq_flag_in = 1'b0, fp_exc_pending_in = 1'b0, fp_target_in = 1'b0;
  logic fp_target_sensitive_in = 1'b0, numeric_error_ctrl_bit_in = 1'b0;
  logic [2:0] beats = 3'h0;
  logic [1:0] gap = 2'h0;
  logic burst_ready_n_in, cacheable_in_n, bus_grant_ack_out, bus_float_out, cyc_allow_out;
  logic snoop_modified_hit_n_out, snoop_update_out, snoop_make_invalid_out, writeback_req_out;
  logic fill_cacheable_out, fill_burst_out, fp_stall_out, fp_continue_out, fp_vector_out;
  logic fp_yield_out, init_take_out, irq_take_out;
  logic [7:0] fp_vector_num_out;
  logic [31:0] restart_addr_out;
  int fails = 0;
  int compares = 0;

  always #50 sys_clk_in = ~sys_clk_in;
  bhc_ctrl DUT (.*);
  bhc_sys_model u_sys (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .go_in(go), .ken_in(ken),
    .beats_in(beats), .gap_in(gap), .burst_ready_n_out(burst_ready_n_in),
    .cacheable_n_out(cacheable_in_n));

  task automatic tick();
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cb(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic bound(input int i);
    if (i > 30) begin
      fails++;
      complete_run();
    end
  endtask
  task automatic start_cyc(input logic rd, wb, ca, page_cache_disable_out, input logic [2:0] n);
    for (int i = 0; cyc_allow_out !== 1'b1; i++) begin
      bound(i);
      tick();
    end
    {cyc_start_in, go, cyc_read_in, cyc_writeback_in, cyc_cache_in} = {2'b11, rd, wb, ca};
    page_cache_disable_in = page_cache_disable_out;
    beats = n;
    tick();
    {cyc_start_in, go} = 2'b00;
  endtask
  task automatic wait_rdy();
    for (int i = 0; burst_ready_n_in !== 1'b0; i++) begin
      bound(i);
      tick();
    end
  endtask
  task automatic fp_at(input logic s, input logic ne);
    {fp_exc_pending_in, fp_target_in, fp_target_sensitive_in} = {2'b11, s};
    numeric_error_ctrl_bit_in = ne;
    instr_boundary_in = 1'b1;
    tick();
    instr_boundary_in = 1'b0;
  endtask

  task automatic t_hold();
    {hold_req_in, backoff_n_in} = 2'b10;
    tick();
    cb("grant idle", 1'b1, bus_grant_ack_out);
    cb("float", 1'b1, bus_float_out);
    hold_req_in = 1'b0;
    tick();
    cb("grant drop", 1'b0, bus_grant_ack_out);
    backoff_n_in = 1'b1;
    gap = 2'h2;
    start_cyc(1'b1, 1'b0, 1'b0, 1'b0, 3'h1);
    gap = 2'h0;
    hold_req_in = 1'b1;
    wait_rdy();
    cb("grant busy", 1'b0, bus_grant_ack_out);
    tick();
    cb("grant after ready", 1'b1, bus_grant_ack_out);
    hold_req_in = 1'b0;
    tick();
  endtask
  task automatic t_lock();
    {lock_seq_in, hold_req_in, init_in} = 3'b111;
    repeat (3) begin
      tick();
      cb("grant locked", 1'b0, bus_grant_ack_out);
    end
    lock_seq_in = 1'b0;
    tick();
    cb("grant unlocked", 1'b1, bus_grant_ack_out);
    {hold_req_in, init_in, instr_boundary_in} = 3'b001;
    tick();
    instr_boundary_in = 1'b0;
    cb("init take", 1'b1, init_take_out);
    chk("restart", 32'hffff_fff0, restart_addr_out);
  endtask
  task automatic t_snoop();
    {snoop_addr_strobe_n_in, snoop_found_in, snoop_modified_in, snoop_invalidate_in} = 4'b0111;
    tick();
    snoop_addr_strobe_n_in = 1'b1;
    cb("snoop_modified_hit_n", 1'b0, snoop_modified_hit_n_out);
    cb("wb req", 1'b1, writeback_req_out);
    cb("update", 1'b1, snoop_update_out);
    cb("invalid", 1'b1, snoop_make_invalid_out);
    start_cyc(1'b0, 1'b1, 1'b1, 1'b0, 3'h4);
    wait_rdy();
    repeat (3) begin
      tick();
      cb("snoop_modified_hit_n held", 1'b0, snoop_modified_hit_n_out);
    end
    tick();
    cb("snoop_modified_hit_n release", 1'b1, snoop_modified_hit_n_out);
    {snoop_addr_strobe_n_in, snoop_modified_in, snoop_invalidate_in} = 3'b000;
    tick();
    snoop_addr_strobe_n_in = 1'b1;
    cb("snoop_modified_hit_n clean", 1'b1, snoop_modified_hit_n_out);
    cb("shared", 1'b0, snoop_make_invalid_out);
    cb("no wb", 1'b0, writeback_req_out);
    start_cyc(1'b0, 1'b1, 1'b1, 1'b0, 3'h4);
    {snoop_addr_strobe_n_in, snoop_modified_in} = 2'b01;
    tick();
    snoop_addr_strobe_n_in = 1'b1;
    cb("snoop_modified_hit_n in wb", 1'b0, snoop_modified_hit_n_out);
    cb("no second wb", 1'b0, writeback_req_out);
    repeat (3) tick();
    cb("snoop_modified_hit_n end wb", 1'b1, snoop_modified_hit_n_out);
    snoop_found_in = 1'b0;
  endtask
  task automatic t_fill();
    logic [3:0] cs [4] = '{4'b1011, 4'b0010, 4'b1110, 4'b1000};
    for (int k = 0; k < 4; k++) begin
      ken = cs[k][3];
      start_cyc(1'b1, 1'b0, cs[k][1], cs[k][2], cs[k][0] ? 3'h4 : 3'h1);
      wait_rdy();
      tick();
      cb("fill burst", cs[k][0], fill_burst_out);
      cb("fill cacheable", cs[k][0], fill_cacheable_out);
      repeat (4) tick();
    end
    {ken, gap} = 3'b101;
    start_cyc(1'b1, 1'b0, 1'b1, 1'b0, 3'h4);
    {next_addr_n_in, gap} = 3'b000;
    tick();
    next_addr_n_in = 1'b1;
    cb("fill on next addr", 1'b1, fill_burst_out);
    repeat (5) tick();
    gap = 2'h2;
    start_cyc(1'b1, 1'b0, 1'b1, 1'b0, 3'h4);
    {backoff_n_in, gap} = 3'b000;
    tick();
    cb("abort float", 1'b1, bus_float_out);
    cb("abort allow", 1'b0, cyc_allow_out);
    backoff_n_in = 1'b1;
    start_cyc(1'b1, 1'b0, 1'b1, 1'b0, 3'h4);
    wait_rdy();
    tick();
    cb("restart fill", 1'b1, fill_burst_out);
    repeat (4) tick();
  endtask
  task automatic t_fp();
    fp_at(1'b0, 1'b1);
    cb("insensitive", 1'b1, fp_continue_out);
    tick();
    fp_at(1'b1, 1'b1);
    cb("vector", 1'b1, fp_vector_out);
    chk("vector num", 32'h10, {24'h0, fp_vector_num_out});
    ignore_fp_error_n_in = 1'b0;
    repeat (3) tick();
    fp_at(1'b1, 1'b0);
    cb("ignored", 1'b1, fp_continue_out);
    ignore_fp_error_n_in = 1'b1;
    repeat (3) tick();
    fp_at(1'b1, 1'b0);
    cb("stall", 1'b1, fp_stall_out);
    ignore_fp_error_n_in = 1'b0;
    for (int i = 0; fp_continue_out !== 1'b1; i++) begin
      bound(i);
      tick();
    end
    cb("stall end", 1'b0, fp_stall_out);
    cb("no yield", 1'b0, fp_yield_out);
    ignore_fp_error_n_in = 1'b1;
    repeat (3) tick();
    fp_at(1'b1, 1'b0);
    maskable_irq_in = 1'b1;
    for (int i = 0; fp_yield_out !== 1'b1; i++) begin
      bound(i);
      tick();
    end
    cb("yield", 1'b0, fp_stall_out);
    {fp_exc_pending_in, irq_flag_in, instr_boundary_in} = 3'b011;
    tick();
    instr_boundary_in = 1'b0;
    cb("irq take", 1'b1, irq_take_out);
    {maskable_irq_in, irq_flag_in} = 2'b00;
  endtask

  initial begin
    repeat (2) @(posedge sys_clk_in);
    #1;
    rst_n_in = 1'b1;
    tick();
    t_hold();
    t_lock();
    t_snoop();
    t_fill();
    t_fp();
    complete_run();
  end
endmodule

// file: verilog/bhc_cfg.svh
// Constants for the bus hold, snoop and interrupt control block.
// Assumes inclusion by bare name from every file that needs the figures.
`ifndef BHC_CFG_SVH
`define BHC_CFG_SVH

`define BHC_RESTART_ADDR 32'hffff_fff0
`define BHC_FP_VECTOR 8'h10
`define BHC_BURST_BEATS 3'h4
`define BHC_SINGLE_BEATS 3'h1
`define BHC_SYNC_STAGES 2
`define BHC_CLK_PERIOD_NS 100

`endif

// file: verilog/bhc_ctrl.sv
// Bus hold, inquire response, cacheability and interrupt sampling control.
// Assumes bus pins are synchronous to sys_clk_in; interrupt style pins may be asynchronous.
`timescale 1ns/1ns
`include "bhc_cfg.svh"

// What this block does
// - Inquire hitting a modified line asserts modified-hit and requests a writeback.
// - Hit on line already being written back asserts modified-hit, no new writeback.
// - Modified-hit driven edge after strobe; negates one edge after writeback's last ready.
// - Grant one edge after last ready if busy, after request if idle.
// - Grant withheld until a locked sequence fully completes.
// - Bus outputs float in every clock the grant is asserted.
// - Grant negates at the same edge that samples the request negated.
// - Grant ignores backoff; grant and modified-hit always driven.
// - Bus request honoured even while init is asserted; reset holds the grant negated.
// - Numeric error bit 0: continue on ignore, else stall until ignore or interrupt.
// - Numeric error bit 1: take vector 10h without consulting ignore.
// - Error-insensitive target instruction ignores the pending exception and continues.
// - Ignore input sampled as a level every edge; async pulses last two clocks.
// - Recognized init restarts fetch at FFFF_FFF0h, keeping caches and control bits.
// - Init latched on rising edge every clock, acted on at instruction boundary.
// - Maskable interrupt sampled as a level, taken at boundary when flag is 1.
// - Invalidate input sampled with snoop strobe: invalid if set, shared otherwise.
// - Cacheable input sampled on first ready or next-address of cached reads only.
// - Cacheable fill runs four beats; otherwise single transfer; page disable blocks caching.
module bhc_ctrl (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic hold_req_in,
  input wire logic backoff_n_in,
  input wire logic burst_ready_n_in,
  input wire logic next_addr_n_in,
  input wire logic cacheable_in_n,
  input wire logic snoop_addr_strobe_n_in,
  input wire logic snoop_invalidate_in,
  input wire logic ignore_fp_error_n_in,
  input wire logic maskable_irq_in,
  input wire logic init_in,
  input wire logic nmi_in,
  input wire logic sys_mgmt_irq_n_in,
  input wire logic cyc_start_in,
  input wire logic cyc_read_in,
  input wire logic cyc_writeback_in,
  input wire logic cyc_cache_in,
  input wire logic page_cache_disable_in,
  input wire logic lock_seq_in,
  input wire logic snoop_found_in,
  input wire logic snoop_modified_in,
  input wire logic instr_boundary_in,
  input wire logic irq_flag_in,
  input wire logic fp_exc_pending_in,
  input wire logic fp_target_in,
  input wire logic fp_target_sensitive_in,
  input wire logic numeric_error_ctrl_bit_in,
  output logic bus_grant_ack_out,
  output logic bus_float_out,
  output logic cyc_allow_out,
  output logic snoop_modified_hit_n_out,
  output logic snoop_update_out,
  output logic snoop_make_invalid_out,
  output logic writeback_req_out,
  output logic fill_cacheable_out,
  output logic fill_burst_out,
  output logic fp_stall_out,
  output logic fp_continue_out,
  output logic fp_vector_out,
  output logic [7:0] fp_vector_num_out,
  output logic fp_yield_out,
  output logic init_take_out,
  output logic [31:0] restart_addr_out,
  output logic irq_take_out
);

  logic [4:0] sync_raw, sync_lvl;
  logic ignore_lvl, maskable_irq_in_lvl, init_lvl, nmi_lvl, smi_lvl;
  // Active-low pins are turned active-high before synchronising.
  assign sync_raw = {!sys_mgmt_irq_n_in, nmi_in, init_in, maskable_irq_in,
                     !ignore_fp_error_n_in};

  bhc_sync #(.WIDTH(5)) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(sync_raw),
    .sync_out(sync_lvl)
  );
  assign {smi_lvl, nmi_lvl, init_lvl, maskable_irq_in_lvl, ignore_lvl} = sync_lvl;

  // Bus cycle tracking and hold arbitration.
  bhc_pkg::bhc_bus_state_type bus_state, next_bus_state;
  logic [2:0] beats_left, next_beats_left;
  logic first_beat, next_first_beat, cur_read, next_cur_read, cur_wb, next_cur_wb;
  logic cur_cache, next_cur_cache, cur_pcd, next_cur_pcd;
  logic next_fill_cacheable, next_fill_burst, next_float, next_allow;
  logic ready, last_ready, take_ken;

  assign ready = !burst_ready_n_in;
  assign last_ready = (bus_state == bhc_pkg::BHC_BUS_CYCLE) && ready && beats_left == 3'h1;
  assign take_ken = (bus_state == bhc_pkg::BHC_BUS_CYCLE) && first_beat && cur_read &&
                    !cur_wb && cur_cache && (ready || !next_addr_n_in);

  always_comb begin
    next_bus_state = bus_state;
    next_beats_left = beats_left;
    next_first_beat = first_beat;
    next_cur_read = cur_read;
    next_cur_wb = cur_wb;
    next_cur_cache = cur_cache;
    next_cur_pcd = cur_pcd;
    next_fill_cacheable = fill_cacheable_out;
    next_fill_burst = fill_burst_out;
    case (bus_state)
      bhc_pkg::BHC_BUS_IDLE: begin
        if (cyc_start_in && cyc_allow_out) begin
          next_bus_state = bhc_pkg::BHC_BUS_CYCLE;
          next_beats_left = cyc_writeback_in ? `BHC_BURST_BEATS : `BHC_SINGLE_BEATS;
          next_first_beat = 1'b1;
          next_cur_read = cyc_read_in;
          next_cur_wb = cyc_writeback_in;
          next_cur_cache = cyc_cache_in;
          next_cur_pcd = page_cache_disable_in;
          next_fill_cacheable = 1'b0;
          next_fill_burst = cyc_writeback_in;
        end else if (hold_req_in && !lock_seq_in) begin
          next_bus_state = bhc_pkg::BHC_BUS_GRANT;
        end
      end
      bhc_pkg::BHC_BUS_CYCLE: begin
        if (!backoff_n_in) begin
          // Backoff aborts the cycle; the core restarts it later.
          next_bus_state = bhc_pkg::BHC_BUS_IDLE;
          next_first_beat = 1'b0;
        end else begin
          if (take_ken) begin
            next_fill_cacheable = !cacheable_in_n && !cur_pcd;
            next_fill_burst = !cacheable_in_n && !cur_pcd;
            next_first_beat = 1'b0;
            if (!cacheable_in_n && !cur_pcd) begin
              // Cacheable fill: four beats, later readies do not sample again.
              next_beats_left = ready ? `BHC_BURST_BEATS - 3'h1 : `BHC_BURST_BEATS;
            end else if (ready) begin
              next_beats_left = beats_left - 3'h1;
            end
          end else if (ready) begin
            next_beats_left = beats_left - 3'h1;
            next_first_beat = 1'b0;
          end
          if (last_ready && !(take_ken && !cacheable_in_n && !cur_pcd)) begin
            if (hold_req_in && !lock_seq_in) begin
              next_bus_state = bhc_pkg::BHC_BUS_GRANT;
            end else begin
              next_bus_state = bhc_pkg::BHC_BUS_IDLE;
            end
          end
        end
      end
      bhc_pkg::BHC_BUS_GRANT: begin
        if (!hold_req_in) begin
          next_bus_state = bhc_pkg::BHC_BUS_IDLE;
        end
      end
      default: begin
        next_bus_state = bhc_pkg::BHC_BUS_IDLE;
      end
    endcase
    next_float = (next_bus_state == bhc_pkg::BHC_BUS_GRANT) || !backoff_n_in;
    next_allow = (next_bus_state == bhc_pkg::BHC_BUS_IDLE) && !hold_req_in &&
                 backoff_n_in;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_state <= bhc_pkg::BHC_BUS_IDLE;
      beats_left <= 3'h0;
      first_beat <= 1'b0;
      cur_read <= 1'b0;
      cur_wb <= 1'b0;
      cur_cache <= 1'b0;
      cur_pcd <= 1'b0;
      fill_cacheable_out <= 1'b0;
      fill_burst_out <= 1'b0;
      bus_float_out <= 1'b0;
      cyc_allow_out <= 1'b0;
      bus_grant_ack_out <= 1'b0;
    end else begin
      bus_state <= next_bus_state;
      beats_left <= next_beats_left;
      first_beat <= next_first_beat;
      cur_read <= next_cur_read;
      cur_wb <= next_cur_wb;
      cur_cache <= next_cur_cache;
      cur_pcd <= next_cur_pcd;
      fill_cacheable_out <= next_fill_cacheable;
      fill_burst_out <= next_fill_burst;
      bus_float_out <= next_float;
      cyc_allow_out <= next_allow;
      bus_grant_ack_out <= (next_bus_state == bhc_pkg::BHC_BUS_GRANT);
    end
  end

  // Inquire responses.
  logic wb_active, next_wb_active, strobe_gap, next_strobe_gap, next_snoop_modified_hit_n_n;
  logic next_wb_req, next_snoop_update, next_make_invalid, snoop_take;

  // A strobe right after a taken one, or while modified-hit is asserted, is ignored.
  assign snoop_take = !snoop_addr_strobe_n_in && !strobe_gap && snoop_modified_hit_n_out;

  always_comb begin
    next_wb_active = wb_active;
    next_snoop_modified_hit_n_n = snoop_modified_hit_n_out;
    next_wb_req = writeback_req_out;
    next_snoop_update = 1'b0;
    next_make_invalid = snoop_make_invalid_out;
    next_strobe_gap = snoop_take;
    if (cyc_start_in && cyc_allow_out && cyc_writeback_in) begin
      next_wb_active = 1'b1;
      next_wb_req = 1'b0;
    end
    if (cur_wb && (last_ready || (bus_state == bhc_pkg::BHC_BUS_CYCLE && !backoff_n_in))) begin
      next_wb_active = 1'b0;
    end
    if (!snoop_modified_hit_n_out && cur_wb && last_ready) begin
      next_snoop_modified_hit_n_n = 1'b1;
    end
    if (snoop_take) begin
      next_snoop_modified_hit_n_n = !(snoop_found_in && snoop_modified_in);
      next_snoop_update = snoop_found_in;
      next_make_invalid = snoop_invalidate_in;
      if (snoop_found_in && snoop_modified_in && !wb_active) begin
        next_wb_req = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wb_active <= 1'b0;
      strobe_gap <= 1'b0;
      snoop_modified_hit_n_out <= 1'b1;
      writeback_req_out <= 1'b0;
      snoop_update_out <= 1'b0;
      snoop_make_invalid_out <= 1'b0;
    end else begin
      wb_active <= next_wb_active;
      strobe_gap <= next_strobe_gap;
      snoop_modified_hit_n_out <= next_snoop_modified_hit_n_n;
      writeback_req_out <= next_wb_req;
      snoop_update_out <= next_snoop_update;
      snoop_make_invalid_out <= next_make_invalid;
    end
  end

  // Init, maskable interrupt and floating-point error handling.
  bhc_pkg::bhc_fp_state_type fp_state, next_fp_state;
  logic init_prev, init_pend, next_init_pend, next_init_take, next_irq_take;
  logic next_fp_continue, next_fp_vector, next_fp_yield, wake;
  assign wake = maskable_irq_in_lvl || smi_lvl || nmi_lvl || init_lvl;

  always_comb begin
    next_fp_state = fp_state;
    next_init_take = 1'b0;
    next_irq_take = 1'b0;
    next_fp_continue = 1'b0;
    next_fp_vector = 1'b0;
    next_fp_yield = 1'b0;
    next_init_pend = init_pend;
    case (fp_state)
      bhc_pkg::BHC_FP_RUN: begin
        if (instr_boundary_in) begin
          if (init_pend) begin
            next_init_take = 1'b1;
            next_init_pend = 1'b0;
          end else if (maskable_irq_in_lvl && irq_flag_in) begin
            next_irq_take = 1'b1;
          end else if (fp_target_in && fp_exc_pending_in) begin
            if (!fp_target_sensitive_in) begin
              next_fp_continue = 1'b1;
            end else if (numeric_error_ctrl_bit_in) begin
              next_fp_vector = 1'b1;
            end else if (ignore_lvl) begin
              next_fp_continue = 1'b1;
            end else begin
              next_fp_state = bhc_pkg::BHC_FP_STALL;
            end
          end
        end
      end
      bhc_pkg::BHC_FP_STALL: begin
        if (ignore_lvl) begin
          next_fp_continue = 1'b1;
          next_fp_state = bhc_pkg::BHC_FP_RUN;
        end else if (wake) begin
          next_fp_yield = 1'b1;
          next_fp_state = bhc_pkg::BHC_FP_RUN;
        end
      end
      default: begin
        next_fp_state = bhc_pkg::BHC_FP_RUN;
      end
    endcase
    // A new rising edge in the same cycle as a take keeps the request pending.
    if (init_lvl && !init_prev) begin
      next_init_pend = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fp_state <= bhc_pkg::BHC_FP_RUN;
      init_prev <= 1'b0;
      init_pend <= 1'b0;
      init_take_out <= 1'b0;
      irq_take_out <= 1'b0;
      fp_continue_out <= 1'b0;
      fp_vector_out <= 1'b0;
      fp_yield_out <= 1'b0;
      fp_stall_out <= 1'b0;
      fp_vector_num_out <= `BHC_FP_VECTOR;
      restart_addr_out <= `BHC_RESTART_ADDR;
    end else begin
      fp_state <= next_fp_state;
      init_prev <= init_lvl;
      init_pend <= next_init_pend;
      init_take_out <= next_init_take;
      irq_take_out <= next_irq_take;
      fp_continue_out <= next_fp_continue;
      fp_vector_out <= next_fp_vector;
      fp_yield_out <= next_fp_yield;
      fp_stall_out <= (next_fp_state == bhc_pkg::BHC_FP_STALL);
      fp_vector_num_out <= `BHC_FP_VECTOR;
      restart_addr_out <= `BHC_RESTART_ADDR;
    end
  end

endmodule

// file: verilog/bhc_pkg.sv
// Types shared by the bus hold, snoop and interrupt control block.
// Assumes nothing beyond a SystemVerilog compiler.
package bhc_pkg;

  typedef enum logic [2:0] {
    BHC_BUS_IDLE = 3'b001,
    BHC_BUS_CYCLE = 3'b010,
    BHC_BUS_GRANT = 3'b100
  } bhc_bus_state_type;

  typedef enum logic [1:0] {
    BHC_FP_RUN = 2'b01,
    BHC_FP_STALL = 2'b10
  } bhc_fp_state_type;

endpackage

// file: verilog/bhc_sync.sv
// Two-stage synchroniser for a group of asynchronous input levels.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
module bhc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
